/* rtl/port_d_e_pin_function_select.v */
// pin function multiplexing for port d pins 0-5 and port e pins 0-1
`timescale 1ns/1ps
`include "pin_select_defines.vh"
// Contract
// - any pin in gpio mode can be set independently as input or output.
// - after reset port d pin 0 is a gpio input with pull-up on.
// - peripheral-enable bit 0 hands d0 to a peripheral and select bit 4 picks chip select two or can transmit.
// - peripheral-enable bit 1 hands d1 to a peripheral and select bit 5 picks chip select three or can receive.
// - d2-d5 reset as gpio and can carry chip selects four to seven.
// - routed chip selects float while the bus is idle unless the bus-idle drive control bit is set.
// - clearing port d pull-up bit n turns off the pull-up on d pin n; reset enables all.
// - d1 as can receive keeps its pull-up active.
// - e0 defaults to serial zero transmit, driver off and pull-up on during reset.
// - e1 defaults to serial zero receive, input with pull-up during reset, reassignable to gpio.
// - clearing port e pull-up bit 0 or 1 turns off that pin's pull-up.
module port_d_e_pin_function_select (
   input wire clk, // system clock
   input wire rstn, // async reset, active low
   input wire cfgWe, // load all configuration inputs this cycle
   input wire [5:0] portDPeripheralEnableIn, // new port d peripheral-enable
   input wire [1:0] portEPeripheralEnableIn, // new port e peripheral-enable
   input wire [7:0] systemPeripheralSelectIn, // new peripheral-select
   input wire [5:0] portDPullupEnableIn, // new port d pull-up enables
   input wire [1:0] portEPullupEnableIn, // new port e pull-up enables
   input wire [5:0] portDDirIn, // new port d directions, 1 = output
   input wire [1:0] portEDirIn, // new port e directions
   input wire [5:0] portDDataIn, // new port d output data
   input wire [1:0] portEDataIn, // new port e output data
   input wire busIdleDriveControlIn, // new bus-idle drive control bit
   input wire busActive, // external bus cycle in progress
   input wire [5:0] chipSelectN, // chip selects two..seven, active low
   input wire canSecondTransmit, // can transmit, open drain low drive
   input wire serialZeroTransmit, // serial port zero transmit
   input wire [5:0] portDPadIn, // port d pad levels
   input wire [1:0] portEPadIn, // port e pad levels
   output wire [5:0] portDPadOut, // port d pad output values
   output wire [5:0] portDPadOe, // port d pad output enables
   output wire [5:0] portDPadPu, // port d pull-up enables
   output wire [1:0] portEPadOut, // port e pad output values
   output wire [1:0] portEPadOe, // port e pad output enables
   output wire [1:0] portEPadPu, // port e pull-up enables
   output reg [5:0] portDDataRd_r, // registered port d pad levels
   output reg [1:0] portEDataRd_r, // registered port e pad levels
   output reg canSecondReceive_r, // registered can receive
   output reg serialZeroReceive_r, // registered serial zero receive
   output wire [5:0] portDPeripheralEnable, // current port d peripheral-enable
   output wire [1:0] portEPeripheralEnable, // current port e peripheral-enable
   output wire busIdleDriveControl // current bus-idle drive control
);
   // ******************************
   // configuration registers
   // ******************************
   reg [5:0] dPer_r;
   reg [1:0] ePer_r;
   reg [7:0] sps_r;
   reg [5:0] dPu_r;
   reg [1:0] ePu_r;
   reg [5:0] dDir_r;
   reg [1:0] eDir_r;
   reg [5:0] dOut_r;
   reg [1:0] eOut_r;
   reg bIdle_r;

   // ******************************
   // configuration next values
   // ******************************
   reg [5:0] dPer_nxt;
   reg [1:0] ePer_nxt;
   reg [7:0] sps_nxt;
   reg [5:0] dPu_nxt;
   reg [1:0] ePu_nxt;
   reg [5:0] dDir_nxt;
   reg [1:0] eDir_nxt;
   reg [5:0] dOut_nxt;
   reg [1:0] eOut_nxt;
   reg bIdle_nxt;

   // all settings hold until the common load strobe; there is no partial write
   always @* begin
      dPer_nxt = dPer_r;
      ePer_nxt = ePer_r;
      sps_nxt = sps_r;
      dPu_nxt = dPu_r;
      ePu_nxt = ePu_r;
      dDir_nxt = dDir_r;
      eDir_nxt = eDir_r;
      dOut_nxt = dOut_r;
      eOut_nxt = eOut_r;
      bIdle_nxt = bIdle_r;
      if (cfgWe) begin
         dPer_nxt = portDPeripheralEnableIn;
         ePer_nxt = portEPeripheralEnableIn;
         sps_nxt = systemPeripheralSelectIn;
         dPu_nxt = portDPullupEnableIn;
         ePu_nxt = portEPullupEnableIn;
         dDir_nxt = portDDirIn;
         eDir_nxt = portEDirIn;
         dOut_nxt = portDDataIn;
         eOut_nxt = portEDataIn;
         bIdle_nxt = busIdleDriveControlIn;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dPer_r <= `PDPER_RST;
         ePer_r <= `PEPER_RST;
         sps_r <= `SPS_RST;
         dPu_r <= `PDPU_RST;
         ePu_r <= `PEPU_RST;
         dDir_r <= `DDIR_RST;
         eDir_r <= `EDIR_RST;
         dOut_r <= `DOUT_RST;
         eOut_r <= `EOUT_RST;
         bIdle_r <= `BIDLE_RST;
      end else begin
         dPer_r <= dPer_nxt;
         ePer_r <= ePer_nxt;
         sps_r <= sps_nxt;
         dPu_r <= dPu_nxt;
         ePu_r <= ePu_nxt;
         dDir_r <= dDir_nxt;
         eDir_r <= eDir_nxt;
         dOut_r <= dOut_nxt;
         eOut_r <= eOut_nxt;
         bIdle_r <= bIdle_nxt;
      end
   end

   assign portDPeripheralEnable = dPer_r;
   assign portEPeripheralEnable = ePer_r;
   assign busIdleDriveControl = bIdle_r;

   // ******************************
   // peripheral routing
   // ******************************
   wire csDrive = busActive | bIdle_r;
   wire d0Can = sps_r[`SPS_D0_BIT];
   wire d1Can = sps_r[`SPS_D1_BIT];
   // can receive routed: pull-up forced on, receive sampled from the pad
   wire canRxRouted = dPer_r[1] & d1Can;
   wire [5:0] dPerOut;
   wire [5:0] dPerOe;
   wire [5:0] dPerPull;
   // d0: chip select two, or can transmit as open drain (drive only low)
   assign dPerOut[0] = d0Can ? 1'b0 : chipSelectN[0];
   assign dPerOe[0] = d0Can ? ~canSecondTransmit : csDrive;
   // d1: chip select three, or can receive input
   assign dPerOut[1] = chipSelectN[1];
   assign dPerOe[1] = d1Can ? 1'b0 : csDrive;
   assign dPerOut[5:2] = chipSelectN[5:2];
   assign dPerOe[5:2] = {4{csDrive}};
   assign dPerPull = {4'h0, canRxRouted, 1'b0};

   // serial zero: e0 transmits, e1 receives
   wire [1:0] ePerOut = {1'b1, serialZeroTransmit};
   wire [1:0] ePerOe = {1'b0, 1'b1};

   // ******************************
   // pin cells
   // ******************************
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : gPin
         wire pOut;
         wire pOe;
         wire pPu;
         if (i < 6) begin : gD
            pin_cell uCell (
               .perEn(dPer_r[i]),
               .gpioDir(dDir_r[i]),
               .gpioOut(dOut_r[i]),
               .perOut(dPerOut[i]),
               .perOe(dPerOe[i]),
               .puEn(dPu_r[i]),
               .perPullForce(dPerPull[i]),
               .padOut(pOut),
               .padOe(pOe),
               .padPu(pPu)
            );
            // driver off during reset, pull-up kept on
            assign portDPadOut[i] = pOut;
            assign portDPadOe[i] = pOe & rstn;
            assign portDPadPu[i] = pPu | ~rstn;
         end else begin : gE
            pin_cell uCell (
               .perEn(ePer_r[i-6]),
               .gpioDir(eDir_r[i-6]),
               .gpioOut(eOut_r[i-6]),
               .perOut(ePerOut[i-6]),
               .perOe(ePerOe[i-6]),
               .puEn(ePu_r[i-6]),
               .perPullForce(1'b0),
               .padOut(pOut),
               .padOe(pOe),
               .padPu(pPu)
            );
            assign portEPadOut[i-6] = pOut;
            assign portEPadOe[i-6] = pOe & rstn;
            assign portEPadPu[i-6] = pPu | ~rstn;
         end
      end
   endgenerate

   // ******************************
   // input capture
   // ******************************
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         portDDataRd_r <= `DRD_RST;
         portEDataRd_r <= `ERD_RST;
         canSecondReceive_r <= `RX_IDLE;
         serialZeroReceive_r <= `RX_IDLE;
      end else begin
         portDDataRd_r <= portDPadIn;
         portEDataRd_r <= portEPadIn;
         // idle-high when the pin is not routed
         canSecondReceive_r <= canRxRouted ? portDPadIn[1] : `RX_IDLE;
         serialZeroReceive_r <= ePer_r[1] ? portEPadIn[1] : `RX_IDLE;
      end
   end
endmodule // port_d_e_pin_function_select

/* inc/pin_select_defines.vh */
// reset values and field positions for the port d / port e pin function select
`ifndef PIN_SELECT_DEFINES_VH
`define PIN_SELECT_DEFINES_VH
// port d peripheral-enable: bit n hands pin n to a peripheral
`define PDPER_RST 6'h00
// port e peripheral-enable: both pins start on serial port zero
`define PEPER_RST 2'h3
// system peripheral-select bits for pins d0 and d1
`define SPS_D0_BIT 4
`define SPS_D1_BIT 5
`define SPS_RST 8'h00
// pull-up enables reset to all on
`define PDPU_RST 6'h3f
`define PEPU_RST 2'h3
`define DDIR_RST 6'h00
`define EDIR_RST 2'h0
`define DOUT_RST 6'h00
`define EOUT_RST 2'h0
`define BIDLE_RST 1'b0
// input capture reset values; receive outputs idle high when not routed
`define DRD_RST 6'h00
`define ERD_RST 2'h0
`define RX_IDLE 1'b1
`endif

/* rtl/pin_cell.v */
// one pin: gpio versus peripheral output/direction selection with peripheral pull-up force
`timescale 1ns/1ps
module pin_cell (
   input wire perEn, // pin handed to peripheral
   input wire gpioDir, // gpio direction, 1 = output
   input wire gpioOut, // gpio output value
   input wire perOut, // peripheral output value
   input wire perOe, // peripheral wants to drive
   input wire puEn, // pull-up enable setting
   input wire perPullForce, // peripheral keeps pull-up active
   output wire padOut, // pad output value
   output wire padOe, // pad output enable
   output wire padPu // pad pull-up enable
);
   // gpio settings only when peripheral disabled
   assign padOut = perEn ? perOut : gpioOut;
   assign padOe = perEn ? perOe : gpioDir;
   assign padPu = puEn | perPullForce;
endmodule // pin_cell

/* verif/pad_partner.sv */
// pad model: far-side drivers, pull-ups and floating pads
`timescale 1ns/1ps
module pad_partner (
   input logic clk, // clock
   input logic [7:0] oe, // enables {e, d}
   input logic [7:0] out, // pad values
   input logic [7:0] pu, // pull-ups
   input logic [7:0] extEn, // far side drives
   input logic [7:0] extVal, // far side level
   output logic [7:0] pad // resolved levels
);
   logic tog = 1'b0;
   always @(posedge clk) tog <= ~tog;
   // a floating pad without pull-up wanders every cycle
   always @* begin
      for (int i = 0; i < 8; i++) pad[i] = oe[i] ? out[i] : extEn[i] ? extVal[i] :
         pu[i] ? 1'b1 : tog ^ i[0];
   end
endmodule // pad_partner

/* verif/port_d_e_pin_function_select_chk.sv */
// assertions on the pin function select ports
`timescale 1ns/1ps
module pin_select_chk (
   input logic clk, // in
   input logic rstn, // in
   input logic cfgWe, // in
   input logic [5:0] portDPeripheralEnableIn, // in
   input logic [7:0] systemPeripheralSelectIn, // in
   input logic [5:0] portDPullupEnableIn, // in
   input logic [1:0] portEPullupEnableIn, // in
   input logic [5:0] portDDirIn, // in
   input logic [5:0] portDDataIn, // in
   input logic busActive, // in
   input logic [5:0] chipSelectN, // in
   input logic canSecondTransmit, // in
   input logic serialZeroTransmit, // in
   input logic [5:0] portDPadIn, // in
   input logic [5:0] portDPadOut, // out
   input logic [5:0] portDPadOe, // out
   input logic [5:0] portDPadPu, // out
   input logic [1:0] portEPadOut, // out
   input logic [1:0] portEPadOe, // out
   input logic [1:0] portEPadPu, // out
   input logic canSecondReceive_r, // out
   input logic [5:0] portDPeripheralEnable, // out
   input logic [1:0] portEPeripheralEnable, // out
   input logic busIdleDriveControl // out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire csOn = busActive | busIdleDriveControl;
   wire [3:0] csPer = portDPeripheralEnable[5:2];
   wire rxSel = portDPeripheralEnableIn[1] & systemPeripheralSelectIn[5];
   sequence canRxCfg; cfgWe && rxSel; endsequence
   sequence canRxHeld; !portDPadOe[1] && portDPadPu[1]; endsequence
   chk_gpio_pads: assert property (cfgWe && !portDPeripheralEnableIn |=>
      portDPadOe == $past(portDDirIn) && portDPadOut == $past(portDDataIn)) else $error("gpio");
   chk_cs_float: assert property ((portDPadOe[5:2] & csPer) == (csPer & {4{csOn}}) &&
      (portDPadOut[5:2] & csPer) == (chipSelectN[5:2] & csPer)) else $error("cs pads");
   chk_can_tx: assert property (cfgWe && portDPeripheralEnableIn[0] &&
      systemPeripheralSelectIn[4] |=> !portDPadOut[0] && portDPadOe[0] == !canSecondTransmit)
      else $error("can tx");
   chk_can_rx: assert property (canRxCfg |=> canRxHeld ##1
      canSecondReceive_r == $past(portDPadIn[1])) else $error("can rx");
   chk_pullup_map: assert property (cfgWe && !rxSel |=> portDPadPu == $past(portDPullupEnableIn)
      && portEPadPu == $past(portEPullupEnableIn)) else $error("pull-ups");
   chk_reset_pads: assert property (@(posedge clk) disable iff (1'b0) !rstn |->
      portDPadOe == 6'h00 && portEPadOe == 2'h0 && &portDPadPu && &portEPadPu) else $error("reset");
   chk_serial_tx: assert property (portEPeripheralEnable[0] |-> portEPadOe[0] &&
      portEPadOut[0] == serialZeroTransmit) else $error("serial tx");
   chk_enable_load: assert property (cfgWe |=>
      portDPeripheralEnable == $past(portDPeripheralEnableIn)) else $error("enable load");
endmodule // pin_select_chk
bind port_d_e_pin_function_select pin_select_chk chk (.*);

/* verif/port_d_e_pin_function_select_tb.sv */
// self-checking bench for the pin function select
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module port_d_e_pin_function_select_tb;
   logic clk = 1'b0, rstn = 1'b0, cfgWe = 1'b0, busActive = 1'b0, busIdleDriveControlIn = 1'b0;
   logic canSecondTransmit = 1'b1, serialZeroTransmit = 1'b1;
   logic [5:0] portDPeripheralEnableIn = 6'h00, portDPullupEnableIn = 6'h3f, portDDirIn = 6'h00;
   logic [5:0] portDDataIn = 6'h00, chipSelectN = 6'h3f;
   logic [1:0] portEPeripheralEnableIn = 2'h3, portEPullupEnableIn = 2'h3, portEDirIn = 2'h0;
   logic [1:0] portEDataIn = 2'h0;
   logic [7:0] systemPeripheralSelectIn = 8'h00, extEn = 8'h00, extVal = 8'h00;
   wire [5:0] portDPadIn, portDPadOut, portDPadOe, portDPadPu, portDDataRd_r, portDPeripheralEnable;
   wire [1:0] portEPadIn, portEPadOut, portEPadOe, portEPadPu, portEDataRd_r, portEPeripheralEnable;
   wire canSecondReceive_r, serialZeroReceive_r, busIdleDriveControl;
   int num_errors = 0, samples_checked = 0;
   always #4 clk = ~clk;
   port_d_e_pin_function_select dut (.*);
   pad_partner far (.clk(clk), .oe({portEPadOe, portDPadOe}), .out({portEPadOut, portDPadOut}),
      .pu({portEPadPu, portDPadPu}), .extEn(extEn), .extVal(extVal), .pad({portEPadIn, portDPadIn}));
   task load;
      cfgWe = 1'b1;
      @(negedge clk);
      cfgWe = 1'b0;
      @(negedge clk);
   endtask
   task t_gpio;
      portEPeripheralEnableIn = 2'h0;
      {portDDirIn, portDDataIn, portEDirIn, portEDataIn} = {6'h15, 6'h0c, 2'h1, 2'h1};
      chipSelectN = 6'h00;
      load;
      `CHK("dOe", 6'h15, portDPadOe)
      `CHK("dOut", 6'h0c, portDPadOut)
      `CHK("eOe", 2'h1, portEPadOe)
      `CHK("eOut", 2'h1, portEPadOut)
      `CHK("rd1", 8'hee, {portEDataRd_r, portDDataRd_r})
      {portDDirIn, portEDirIn} = {6'h2a, 2'h2};
      load;
      `CHK("dOe2", 6'h2a, portDPadOe)
      `CHK("eOe2", 2'h2, portEPadOe)
      `CHK("rd2", 8'h5d, {portEDataRd_r, portDDataRd_r})
   endtask
   task t_cs;
      {portDPeripheralEnableIn, portDDirIn, chipSelectN} = {6'h3d, 6'h00, 6'h2a};
      load;
      `CHK("csIdle", 6'h00, portDPadOe)
      busActive = 1'b1;
      @(negedge clk);
      `CHK("csOe", 6'h3d, portDPadOe)
      `CHK("csOut", 6'h28, portDPadOut & 6'h3d)
      busActive = 1'b0;
      busIdleDriveControlIn = 1'b1;
      load;
      `CHK("csDrv", 6'h3d, portDPadOe)
      `CHK("drvBit", 1'b1, busIdleDriveControl)
   endtask
   task t_can;
      {portDPeripheralEnableIn, systemPeripheralSelectIn} = {6'h03, 8'h30};
      {portDPullupEnableIn, portEPullupEnableIn} = {6'h00, 2'h0};
      load;
      `CHK("canOe", 2'h0, portDPadOe[1:0])
      `CHK("pu", 8'h02, {portEPadPu, portDPadPu})
      canSecondTransmit = 1'b0;
      extEn = 8'h02;
      repeat (2) @(negedge clk);
      `CHK("txDom", 2'h2, {portDPadOe[0], portDPadOut[0]})
      `CHK("rxDom", 1'b0, canSecondReceive_r)
      extEn = 8'h00;
      repeat (2) @(negedge clk);
      `CHK("rxIdle", 1'b1, canSecondReceive_r)
   endtask
   task t_serial;
      {portDPeripheralEnableIn, portEPeripheralEnableIn, serialZeroTransmit} = {6'h00, 2'h3, 1'b0};
      extEn = 8'h80;
      load;
      @(negedge clk);
      `CHK("tx", 2'h2, {portEPadOe[0], portEPadOut[0]})
      `CHK("rx", 1'b0, serialZeroReceive_r)
   endtask
   task t_reset;
      rstn = 1'b0;
      @(negedge clk);
      `CHK("rstOe", 8'h00, {portEPadOe, portDPadOe})
      `CHK("rstPu", 8'hff, {portEPadPu, portDPadPu})
      rstn = 1'b1;
      @(negedge clk);
      `CHK("dPer1", 6'h00, portDPeripheralEnable)
      `CHK("dPu1", 6'h3f, portDPadPu)
      `CHK("ePer1", 2'h3, portEPeripheralEnable)
      `CHK("drv1", 1'b0, busIdleDriveControl)
   endtask
   task final_report;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #20000;
      num_errors++;
      final_report;
   end
   initial begin
      repeat (16) @(negedge clk);
      `CHK("rstEOe", 2'h0, portEPadOe)
      rstn = 1'b1;
      @(negedge clk);
      `CHK("dOe0", 6'h00, portDPadOe)
      `CHK("dPu0", 6'h3f, portDPadPu)
      `CHK("ePer0", 2'h3, portEPeripheralEnable)
      `CHK("eOe0", 2'h1, portEPadOe)
      t_gpio;
      t_cs;
      t_can;
      t_serial;
      t_reset;
      final_report;
   end
endmodule // port_d_e_pin_function_select_tb
